// ==== include/tass_pkg.sv ====
// Constants, state encoding and bit layout of the touch converter sequencer.
// Assumes every count below is in bit-clock edges seen by the mclk domain.
// Contract
// - Select 00: finish the conversion, then power down, pen interrupt enabled.
// - Next conversion starts at full power at once, first result valid.
// - Select 00 powered down: negative-Y driver switch stays closed.
// - Select 01: like 00, pen interrupt disabled, negative-Y switch open.
// - Select 10: permanently full power, pen interrupt enabled.
// - Select 11: permanently full power, pen interrupt disabled.
// - Power up on 4th falling edge after start, down on 20th.
// - Bit clock is both conversion and transfer clock; 24 clocks per cycle.
// - Chip select falling takes busy and data output out of tri-state.
// - Control word sampled on the first eight rising bit-clock edges.
// - Word updated bit by bit; acquisition starts once channel is known.
// - After three acquisition cycles latch power-down bits, start converting.
// - Conversion start: hold input, busy high until next falling edge.
// - Ratiometric reference keeps driver switches closed during the conversion.
// - Data output is driven low while the control bits are written; an earlier result still shifts out under an overlapping word.
// - MSB out on ninth falling edge; 9 zeros, 12 bits, 3 zeros.
// - Word written and conversion started only after a start flag.
// - Chip select rising: tri-state outputs, ignore input, abort conversion.
// - With chip select low, keep watching for the next start flag.
// - 12-bit mode: new start ignored until seven clocks after the word.
// - 8-bit mode: new start ignored until three clocks after the word.
// - Next control word accepted while the current conversion still runs.
// - First high serial bit is the start flag; input ignored before it.
// - Word layout: start 7, channel 6..4, resolution 3, reference 2, power 1..0.
// - Resolution bit 0 gives 12-bit conversion, 1 gives 8-bit.
// - Reference bit 1 single-ended, 0 ratiometric.
package tass_pkg;

  typedef enum logic [1:0] {
    tass_idle,
    tass_write,
    tass_acquire,
    tass_convert
  } tass_phase_e;

  // Control word field positions
  localparam int CW_START = 7;
  localparam int CW_CHAN_HI = 6;
  localparam int CW_CHAN_LO = 4;
  localparam int CW_MODE = 3;
  localparam int CW_REF = 2;

  // Rising-edge counts from the start flag (start flag is edge 1)
  localparam logic [4:0] RISE_CHAN = 5'h04;
  localparam logic [4:0] RISE_MODE = 5'h05;
  localparam logic [4:0] RISE_REF = 5'h06;
  localparam logic [4:0] RISE_WORD = 5'h08;
  localparam logic [4:0] GUARD_12 = 5'h07;
  localparam logic [4:0] GUARD_8 = 5'h03;
  localparam logic [4:0] CNT_SAT = 5'h1F;

  // Falling-edge counts from the start flag
  localparam logic [4:0] FALL_PWR_UP = 5'h04;
  localparam logic [4:0] FALL_HOLD = 5'h08;

  // Result lengths
  localparam logic [3:0] NBITS_12 = 4'hC;
  localparam logic [3:0] NBITS_8 = 4'h8;

  // Values after reset, and power select 11
  localparam logic [1:0] PD_RESET = 2'h0;
  localparam logic [1:0] PD_ALWAYS_ON = 2'h3;
  localparam logic CS_N_RESET = 1'b1;

endpackage

// ==== include/tass_sync_if.sv ====
// Carrier between the pin synchroniser and the sequencer.
// Assumes both ends run on mclk; all signals are already synchronised.
interface tass_sync_if;
  logic cs_n_q;
  logic din_q;
  logic clk_rise;
  logic clk_fall;

  modport src (
    output cs_n_q,
    output din_q,
    output clk_rise,
    output clk_fall
  );

  modport dst (
    input cs_n_q,
    input din_q,
    input clk_rise,
    input clk_fall
  );
endinterface

// ==== rtl/tass_pin_sync.sv ====
// Two-flop synchronisers for chip select, bit clock and serial input,
// plus edge detection of the bit clock in the mclk domain.
// Assumes mclk runs well above twice the bit-clock rate.
module tass_pin_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic bit_clock,
  input wire logic serial_in,
  tass_sync_if.src sif
);

  typedef struct packed {
    logic cs_m;
    logic cs_q;
    logic ck_m;
    logic ck_q;
    logic ck_d;
    logic din_m;
    logic din_q;
  } tass_sync_s;

  tass_sync_s s;
  tass_sync_s next_s;

  // First stages feed only the second stages
  always_comb begin
    next_s = s;
    next_s.cs_m = cs_n;
    next_s.cs_q = s.cs_m;
    next_s.ck_m = bit_clock;
    next_s.ck_q = s.ck_m;
    next_s.ck_d = s.ck_q;
    next_s.din_m = serial_in;
    next_s.din_q = s.din_m;
  end

  // Deselected after reset so nothing is driven
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.cs_m <= tass_pkg::CS_N_RESET;
      s.cs_q <= tass_pkg::CS_N_RESET;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Edge pulses last one mclk cycle
  assign sif.cs_n_q = s.cs_q;
  assign sif.din_q = s.din_q;
  assign sif.clk_rise = s.ck_q & ~s.ck_d;
  assign sif.clk_fall = ~s.ck_q & s.ck_d;

endmodule

// ==== rtl/tass_seq.sv ====
// Serial command and conversion sequencer of the touch converter.
// Assumes the host bit clock is far slower than mclk; result bits come
// from the converter core on result_data, steady from hold onward.
module tass_seq (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic bit_clock,
  input wire logic serial_in,
  input wire logic [11:0] result_data,
  output logic serial_out,
  output logic serial_out_oe,
  output logic busy,
  output logic busy_oe,
  output logic [2:0] channel_select,
  output logic reference_select,
  output logic resolution_8bit,
  output logic power_down_select_high,
  output logic power_down_select_low,
  output logic powered_up,
  output logic track_hold,
  output logic driver_switches_on,
  output logic neg_y_switch_on,
  output logic pen_irq_enable
);

  typedef struct packed {
    tass_pkg::tass_phase_e ph;
    logic [4:0] rcnt;
    logic [4:0] fcnt;
    logic [7:0] cw;
    logic [2:0] chan;
    logic mode;
    logic refsel;
    logic [1:0] pd;
    logic [11:0] sr;
    logic [3:0] cc;
    logic dout;
    logic busy;
    logic hold;
    logic pwr;
    logic pen_en;
    logic drv;
  } tass_state_s;

  tass_state_s s;
  tass_state_s next_s;
  tass_sync_if sif ();

  tass_pin_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cs_n(cs_n),
    .bit_clock(bit_clock),
    .serial_in(serial_in),
    .sif(sif)
  );

  logic in_word;
  logic armed;
  logic [4:0] guard_end;
  logic [7:0] cw_shift;
  logic [4:0] rcnt_inc;
  logic [4:0] fcnt_inc;

  // Helpers shared by the next-state logic and the checks
  // Start guard depends on the newest resolution bit
  assign guard_end = s.mode ? tass_pkg::RISE_WORD + tass_pkg::GUARD_8
                            : tass_pkg::RISE_WORD + tass_pkg::GUARD_12;
  assign in_word = (s.ph == tass_pkg::tass_write) ||
                   (s.ph == tass_pkg::tass_acquire);
  // Armed when idle or past the guard of the last word
  assign armed = (s.ph == tass_pkg::tass_idle) || (s.rcnt >= guard_end);
  assign cw_shift = {s.cw[6:0], sif.din_q};
  assign rcnt_inc = (s.rcnt == tass_pkg::CNT_SAT) ? s.rcnt : s.rcnt + 5'h01;
  assign fcnt_inc = (s.fcnt == tass_pkg::CNT_SAT) ? s.fcnt : s.fcnt + 5'h01;

  // Sequencer next state
  always_comb begin
    next_s = s;
    if (sif.cs_n_q) begin
      next_s.ph = tass_pkg::tass_idle;
      next_s.rcnt = tass_pkg::CNT_SAT;
      next_s.fcnt = tass_pkg::CNT_SAT;
      next_s.cc = '0;
      next_s.busy = 1'b0;
      next_s.hold = 1'b0;
      next_s.dout = 1'b0;
      next_s.drv = 1'b0;
      next_s.pwr = s.pd[1];
      next_s.pen_en = ~s.pd[0];
    end else if (sif.clk_rise) begin
      if (armed && sif.din_q) begin
        // Start flag opens a new control word
        next_s.ph = tass_pkg::tass_write;
        next_s.rcnt = 5'h01;
        next_s.fcnt = 5'h00;
        next_s.cw = 8'h01;
        next_s.pen_en = 1'b0;
      end else if (s.ph != tass_pkg::tass_idle) begin
        next_s.rcnt = rcnt_inc;
        // Control bits sampled on rising edges, MSB first
        if (s.rcnt < tass_pkg::RISE_WORD) begin
          next_s.cw = cw_shift;
        end
        case (rcnt_inc)
          tass_pkg::RISE_CHAN: begin
            next_s.chan = cw_shift[2:0];
            next_s.ph = tass_pkg::tass_acquire;
            next_s.drv = 1'b1;
          end
          tass_pkg::RISE_MODE: begin
            next_s.mode = cw_shift[0];
          end
          tass_pkg::RISE_REF: begin
            next_s.refsel = cw_shift[0];
          end
          tass_pkg::RISE_WORD: begin
            // Power bits latched once the word is complete
            if (s.ph == tass_pkg::tass_acquire) begin
              next_s.pd = cw_shift[1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sif.clk_fall) begin
      // Falling edges pace conversion and output
      next_s.fcnt = fcnt_inc;
      next_s.busy = 1'b0;
      // Full power on the 4th falling edge, no extra delay
      if (in_word && fcnt_inc == tass_pkg::FALL_PWR_UP) begin
        next_s.pwr = 1'b1;
      end
      if (s.ph == tass_pkg::tass_acquire &&
          fcnt_inc == tass_pkg::FALL_HOLD) begin
        // Hold the input, busy for one bit-clock cycle
        next_s.ph = tass_pkg::tass_convert;
        next_s.hold = 1'b1;
        next_s.busy = 1'b1;
        next_s.sr = result_data;
        next_s.dout = 1'b0;
        next_s.cc = s.mode ? tass_pkg::NBITS_8 : tass_pkg::NBITS_12;
        // Single-ended may release drivers, ratiometric not
        if (s.refsel && s.pd != tass_pkg::PD_ALWAYS_ON) begin
          next_s.drv = 1'b0;
        end
      end else if (s.cc != 4'h0) begin
        // Result MSB first; runs on under a new word
        next_s.dout = s.sr[11];
        next_s.sr = {s.sr[10:0], 1'b0};
        next_s.cc = s.cc - 4'h1;
        if (s.cc == 4'h1) begin
          // End of conversion: power per select
          next_s.hold = 1'b0;
          next_s.pwr = s.pd[1] ||
                       (in_word && fcnt_inc >= tass_pkg::FALL_PWR_UP);
          if (s.pd != tass_pkg::PD_ALWAYS_ON && !in_word) begin
            next_s.drv = 1'b0;
          end
          // Pen interrupt enable restored from select
          next_s.pen_en = ~s.pd[0] & ~in_word;
          if (s.ph == tass_pkg::tass_convert) begin
            next_s.ph = tass_pkg::tass_idle;
          end
        end
      end else begin
        // Zeros while writing and after the last bit
        next_s.dout = 1'b0;
      end
    end
  end

  // State register; clk_en low freezes everything
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ph <= tass_pkg::tass_idle;
      s.rcnt <= tass_pkg::CNT_SAT;
      s.fcnt <= tass_pkg::CNT_SAT;
      s.pd <= tass_pkg::PD_RESET;
      s.pen_en <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs; tri-state enables follow the synchronised chip select
  // Drive only while selected
  assign serial_out_oe = ~sif.cs_n_q;
  assign busy_oe = ~sif.cs_n_q;
  assign serial_out = s.dout;
  assign busy = s.busy;
  assign channel_select = s.chan;
  assign reference_select = s.refsel;
  assign resolution_8bit = s.mode;
  assign power_down_select_high = s.pd[1];
  assign power_down_select_low = s.pd[0];
  assign powered_up = s.pwr;
  assign track_hold = s.hold;
  assign driver_switches_on = s.drv;
  // Negative-Y switch closed only when powered down with 00
  assign neg_y_switch_on = ~s.pwr & (s.pd == tass_pkg::PD_RESET);
  assign pen_irq_enable = s.pen_en;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_hold_start;
    clk_en && !sif.cs_n_q && sif.clk_fall &&
    s.ph == tass_pkg::tass_acquire && fcnt_inc == tass_pkg::FALL_HOLD;
  endsequence

  sequence s_pwr_edge;
    clk_en && !sif.cs_n_q && sif.clk_fall && in_word &&
    fcnt_inc == tass_pkg::FALL_PWR_UP;
  endsequence

  // Last result fall of a conversion with no word behind it
  sequence s_conv_end;
    clk_en && !sif.cs_n_q && sif.clk_fall && s.cc == 4'h1 &&
    s.ph == tass_pkg::tass_convert;
  endsequence

  oe_follows_cs_a: assert property (
    sif.cs_n_q != serial_out_oe && sif.cs_n_q != busy_oe)
    else $error("output enables do not follow chip select");

  cs_abort_a: assert property (
    clk_en && sif.cs_n_q |=> !busy && s.cc == 4'h0 && !track_hold)
    else $error("conversion not aborted on deselect");

  busy_one_fall_a: assert property (
    s_hold_start |=> busy && s.cc == (s.mode ? 4'h8 : 4'hC))
    else $error("busy or length wrong at conversion start");

  busy_clears_a: assert property (
    busy && clk_en && sif.clk_fall |=> !busy)
    else $error("busy not cleared on next falling edge");

  power_up_a: assert property (
    s_pwr_edge |=> powered_up)
    else $error("no power up on fourth falling edge");

  permanent_power_a: assert property (
    s.pd[1] |-> powered_up)
    else $error("select 1x is not at full power");

  start_needs_flag_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && !sif.din_q &&
    s.ph == tass_pkg::tass_idle |=> s.ph == tass_pkg::tass_idle)
    else $error("word started without start flag");

  start_guard_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && s.ph != tass_pkg::tass_idle &&
    s.rcnt < guard_end |=> s.rcnt != 5'h01)
    else $error("start flag accepted inside the guard");

  pd_latch_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && s.ph == tass_pkg::tass_acquire &&
    s.rcnt == 5'h07 |=> s.pd == $past(cw_shift[1:0]))
    else $error("power bits not latched at word end");

  // Old result bits may still run out under a new word, so only idle falls
  dout_low_write_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_fall && s.ph == tass_pkg::tass_write &&
    s.cc == 4'h0 |=> !serial_out)
    else $error("data output not low during write");

  ratio_drivers_a: assert property (
    s_hold_start and !s.refsel |=> driver_switches_on)
    else $error("ratiometric drivers opened at hold");

  // Power and pen state after a conversion, per select
  end_power_down_a: assert property (
    s_conv_end and s.pd == tass_pkg::PD_RESET |=>
      !powered_up && pen_irq_enable && neg_y_switch_on)
    else $error("select 00 did not power down at conversion end");

  end_no_pen_a: assert property (
    s_conv_end and s.pd[0] |=> !pen_irq_enable)
    else $error("pen interrupt enabled with select x1");

  neg_y_open_a: assert property (
    s_conv_end and s.pd == 2'h1 |=> !powered_up && !neg_y_switch_on)
    else $error("select 01 left power or negative-Y switch on");

  always_on_a: assert property (
    s_conv_end and s.pd == 2'h2 |=> powered_up && pen_irq_enable)
    else $error("select 10 not powered with pen interrupt");

  // Result framing on the data output
  result_capture_a: assert property (
    s_hold_start |=> s.sr == $past(result_data))
    else $error("result not captured at hold");

  shift_msb_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_fall && s.cc != 4'h0 |=>
      serial_out == $past(s.sr[11]))
    else $error("result bit not shifted out MSB first");

  trailing_zeros_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_fall && s.cc == 4'h0 &&
    s.ph != tass_pkg::tass_write |=> !serial_out)
    else $error("data output not zero outside the result");

  // Control word capture and start detection
  guard_eight_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && s.mode &&
    s.ph != tass_pkg::tass_idle &&
    s.rcnt < tass_pkg::RISE_WORD + tass_pkg::GUARD_8 |=> s.rcnt != 5'h01)
    else $error("start flag accepted inside the 8-bit guard");

  chan_latch_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && s.ph == tass_pkg::tass_write &&
    s.rcnt == 5'h03 |=> channel_select == $past(cw_shift[2:0]) &&
      driver_switches_on && s.ph == tass_pkg::tass_acquire)
    else $error("channel or drivers not set at acquisition start");

  word_restart_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise && armed && sif.din_q |=>
      s.ph == tass_pkg::tass_write && s.rcnt == 5'h01 && !pen_irq_enable)
    else $error("start flag did not open a control word");

  mode_latch_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise &&
    s.ph == tass_pkg::tass_acquire && s.rcnt == 5'h04 |=>
      resolution_8bit == $past(sif.din_q))
    else $error("resolution bit not taken on the fifth rise");

  ref_latch_a: assert property (
    clk_en && !sif.cs_n_q && sif.clk_rise &&
    s.ph == tass_pkg::tass_acquire && s.rcnt == 5'h05 |=>
      reference_select == $past(sif.din_q))
    else $error("reference bit not taken on the sixth rise");

endmodule

// ==== testbench/tass_host_model.sv ====
// Host side of the touch converter link: chip select, bit clock, data.
// Assumes the device samples on rising and shifts on falling bit-clock edges.
module tass_host_model (
  output logic cs_n,
  output logic bit_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic busy,
  input wire logic busy_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bit clock stands still low outside frames
  initial begin
    cs_n = 1'b1;
    bit_clock = 1'b0;
    serial_in = 1'b0;
  end

  // Settle time lets the chip-select synchroniser catch up
  task automatic open_frame();
    cs_n = 1'b0;
    serial_in = 1'b0;
    #200;
  endtask

  // Released data line flips so a stale level never looks valid
  task automatic close_frame();
    #62.5;
    cs_n = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask

  // host clock paces transfer, word presented MSB first
  task automatic run(input logic [47:0] din, input int n,
                     output logic [47:0] dout, output logic [47:0] bsy);
    dout = '0;
    bsy = '0;
    for (int k = 0; k < n; k++) begin
      serial_in = din[47-k];
      #62.5;
      bit_clock = 1'b1;
      // Undriven lines read as unknown and can never match
      dout[47-k] = serial_out_oe ? serial_out : 1'bx;
      bsy[47-k] = busy_oe ? busy : 1'bx;
      #62.5;
      bit_clock = 1'b0;
    end
  endtask
endmodule

// ==== testbench/tass_seq_tb.sv ====
// Self-checking bench of the touch converter sequencer.
// Assumes the host model drives the link and result_data stays constant.
module tass_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] RES = 12'hA5C;
  logic mclk, reset_n, cs_n, bit_clock, serial_in, serial_out;
  logic serial_out_oe, busy, busy_oe, reference_select, resolution_8bit;
  logic power_down_select_high, power_down_select_low, powered_up;
  logic track_hold, driver_switches_on, neg_y_switch_on, pen_irq_enable;
  logic [2:0] channel_select;
  logic [47:0] d, b;
  logic [7:0] w;
  int err_count, n_checks;

  tass_seq i_tass_seq (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
    .cs_n(cs_n), .bit_clock(bit_clock), .serial_in(serial_in),
    .result_data(RES), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy(busy), .busy_oe(busy_oe),
    .channel_select(channel_select), .reference_select(reference_select),
    .resolution_8bit(resolution_8bit),
    .power_down_select_high(power_down_select_high),
    .power_down_select_low(power_down_select_low),
    .powered_up(powered_up), .track_hold(track_hold),
    .driver_switches_on(driver_switches_on),
    .neg_y_switch_on(neg_y_switch_on), .pen_irq_enable(pen_irq_enable));

  tass_host_model i_tass_host_model (.cs_n(cs_n), .bit_clock(bit_clock),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy(busy), .busy_oe(busy_oe));

  // start, channel, resolution, reference, power select
  function automatic logic [7:0] cw(logic [2:0] ch, logic m, logic r,
                                     logic [1:0] pd);
    return {1'b1, ch, m, r, pd};
  endfunction

  task automatic chk1(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic chkv(input logic [47:0] got, input logic [47:0] exp,
                      input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Far above the few tens of microseconds the tests need
  initial begin
    #300us;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    #50;
    chk1(serial_out_oe, 1'b0, "oe after reset");
    chk1(pen_irq_enable, 1'b1, "pen after reset");
    chk1(neg_y_switch_on, 1'b1, "neg y after reset");
    $display("test reset done");
    // Every power select, 12-bit ratiometric, one frame each
    for (int p = 0; p < 4; p++) begin
      w = cw(3'h1, 1'b0, 1'b0, 2'(p));
      i_tass_host_model.open_frame();
      chk1(busy_oe, 1'b1, "busy driven");
      i_tass_host_model.run({w, 40'h0}, 8, d, b);
      #60;
      chkv(d, 48'h0, "zeros while writing");
      chk1(powered_up, 1'b1, "powered in conversion");
      chk1(track_hold, 1'b1, "hold after word");
      chk1(driver_switches_on, 1'b1, "ratiometric drivers");
      chk1(pen_irq_enable, 1'b0, "pen off after start");
      i_tass_host_model.run(48'h0, 16, d, b);
      #60;
      chkv(d, {1'b0, RES, 3'h0, 32'h0}, "result 12");
      chkv(b, {1'b1, 47'h0}, "busy pulse");
      chk1(powered_up, p[1], "power after end");
      chk1(pen_irq_enable, !p[0], "pen after end");
      chk1(neg_y_switch_on, p == 0, "neg y switch");
      chk1(track_hold, 1'b0, "track after end");
      chkv({45'h0, channel_select}, 48'h1, "channel");
      chk1(power_down_select_high, p[1], "select high");
      chk1(power_down_select_low, p[0], "select low");
      i_tass_host_model.close_frame();
      chk1(serial_out_oe, 1'b0, "oe released");
    end
    $display("test power modes done");
    // 8-bit single-ended
    i_tass_host_model.open_frame();
    i_tass_host_model.run({cw(3'h3, 1'b1, 1'b1, 2'h0), 40'h0}, 8, d, b);
    #60;
    chk1(driver_switches_on, 1'b0, "single-ended drivers");
    chk1(resolution_8bit, 1'b1, "mode bit");
    chk1(reference_select, 1'b1, "reference bit");
    i_tass_host_model.run(48'h0, 16, d, b);
    chkv(d, {1'b0, RES[11:4], 7'h0, 32'h0}, "result 8");
    $display("test eight bit done");
    // Overlapped words and early starts, all in one frame
    w = cw(3'h5, 1'b0, 1'b0, 2'h2);
    i_tass_host_model.run({w, 7'h0, w, 25'h0}, 39, d, b);
    chkv(d, {9'h0, RES, 3'h0, RES, 12'h0}, "overlap 12");
    chkv(b, {8'h0, 1'b1, 14'h0, 1'b1, 24'h0}, "busy 12");
    i_tass_host_model.run({w, 6'h0, 1'b1, 33'h0}, 24, d, b);
    chkv(d, {9'h0, RES, 27'h0}, "early 12");
    chkv(b, {8'h0, 1'b1, 39'h0}, "busy early 12");
    w = cw(3'h2, 1'b1, 1'b1, 2'h3);
    i_tass_host_model.run({w, 3'h0, w, 29'h0}, 31, d, b);
    chkv(d, {9'h0, RES[11:4], 3'h0, RES[11:4], 20'h0}, "overlap 8");
    chkv(b, {8'h0, 1'b1, 10'h0, 1'b1, 28'h0}, "busy 8");
    i_tass_host_model.run({w, 2'h0, 1'b1, 37'h0}, 24, d, b);
    chkv(b, {8'h0, 1'b1, 39'h0}, "busy early 8");
    i_tass_host_model.close_frame();
    $display("test overlap done");
    // Abort mid-conversion, then a word after idle zeros
    w = cw(3'h1, 1'b0, 1'b0, 2'h0);
    i_tass_host_model.open_frame();
    i_tass_host_model.run({w, 40'h0}, 12, d, b);
    i_tass_host_model.close_frame();
    chk1(track_hold, 1'b0, "aborted hold");
    chk1(busy_oe, 1'b0, "busy released");
    i_tass_host_model.open_frame();
    i_tass_host_model.run({3'h0, w, 37'h0}, 27, d, b);
    chkv(d, {12'h0, RES, 24'h0}, "late start");
    chkv(b, {11'h0, 1'b1, 36'h0}, "busy late start");
    i_tass_host_model.close_frame();
    $display("test abort done");
    finish_test();
  end
endmodule
